// *** bench/lpc_far_model.sv ***
// far-side model: comparator source and wakeup controller
// assumes one pclk domain; the bench calls set_raw to move the outputs
`timescale 1ns/1ps
module lpc_far_model (
    input  wire logic  pclk,        // system main clock
    input  wire logic  cmp_wakeup,  // wakeup request pulse
    output logic [1:0] cmp_raw,     // comparator outputs
    output int         wake_count   // wakeup pulses seen
);
    initial cmp_raw = 2'h0;
    initial wake_count = 0;
    always @(posedge pclk) begin
        if (cmp_wakeup === 1'b1) wake_count <= wake_count + 1;
    end
    // hold each level long enough to pass the synchroniser
    task automatic set_raw(input logic [1:0] v);
        @(posedge pclk);
        cmp_raw <= v;
        repeat (6) @(posedge pclk);
    endtask : set_raw
endmodule : lpc_far_model

// *** bench/lpc_irq_bench.sv ***
// testbench for lpc_irq: apb register tests and comparator events
// assumes lpc_pkg map and a far-side model that drives the raw outputs
`timescale 1ns/1ps
module lpc_irq_bench;
    import lpc_pkg::*;
    logic         pclk, presetn, deep_sleep, irq, wake, err;
    lpc_apb_req_s req;
    lpc_apb_rsp_s rsp;
    logic [1:0]   cmp_raw, pin_out, on;
    logic [31:0]  rd;
    int           failures, checked, cycles, wc;
    lpc_irq dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .cmp_raw(cmp_raw), .deep_sleep(deep_sleep), .cmp_pin_out(pin_out),
        .cmp_on(on), .cmp_irq(irq), .cmp_wakeup(wake));
    lpc_far_model far_u (.pclk(pclk), .cmp_wakeup(wake), .cmp_raw(cmp_raw),
        .wake_count(wc));
    // clock at 50 ns
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(negedge pclk);
    endtask : apb
    // verdict and end of run
    task automatic test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            test_done();
        end
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        deep_sleep = 1'b0;
        req = '0;
        failures = 0;
        checked = 0;
        cycles = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and an unmapped address
        apb(1'b0, LPC_CFG_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, LPC_FLAG_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, LPC_MASK_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        check(err, 1'b1);
        // every edge-select code on both comparators, rise then fall
        apb(1'b1, LPC_MASK_OFS, 32'h1);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, LPC_CFG_OFS, 32'h8080 | (s << 4) | (s << 12));
            check(on, 2'h3);
            far_u.set_raw(2'h3);
            check(pin_out, 2'h3);
            apb(1'b0, LPC_CFG_OFS, 32'h0);
            check(rd, 32'hC0C0 | (s << 4) | (s << 12));
            apb(1'b0, LPC_FLAG_OFS, 32'h0);
            check(rd, 3 * (s & 1));
            check(irq, s & 1);
            apb(1'b1, LPC_FLAG_OFS, 32'h3);
            far_u.set_raw(2'h0);
            apb(1'b0, LPC_FLAG_OFS, 32'h0);
            check(rd, 3 * ((s >> 1) & 1));
            apb(1'b1, LPC_FLAG_OFS, 32'h3);
            check(irq, 1'b0);
        end
        // comparator 1 on falling edge, comparator 0 off, mask on 0 only
        apb(1'b1, LPC_CFG_OFS, 32'hA000);
        far_u.set_raw(2'h2);
        apb(1'b0, LPC_CFG_OFS, 32'h0);
        check(rd, 32'hE000);
        far_u.set_raw(2'h1);
        apb(1'b0, LPC_FLAG_OFS, 32'h0);
        check(rd, 32'h2);
        check(irq, 1'b0);
        apb(1'b0, LPC_MASKED_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, LPC_FLAG_OFS, 32'h0);
        apb(1'b0, LPC_FLAG_OFS, 32'h0);
        check(rd, 32'h2);
        // software force and mask gating
        apb(1'b1, LPC_FORCE_OFS, 32'h3);
        apb(1'b0, LPC_FLAG_OFS, 32'h0);
        check(rd, 32'h3);
        apb(1'b0, LPC_FORCE_OFS, 32'h0);
        check(rd, 32'h3);
        apb(1'b1, LPC_MASK_OFS, 32'h2);
        check(irq, 1'b1);
        apb(1'b0, LPC_MASKED_OFS, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, LPC_FLAG_OFS, 32'h3);
        check(irq, 1'b0);
        // deep sleep wakeup, first masked then unmasked
        @(posedge pclk);
        deep_sleep <= 1'b1;
        apb(1'b1, LPC_CFG_OFS, 32'h90);
        far_u.set_raw(2'h0);
        far_u.set_raw(2'h1);
        check(wc, 32'h0);
        apb(1'b1, LPC_FLAG_OFS, 32'h3);
        apb(1'b1, LPC_MASK_OFS, 32'h1);
        far_u.set_raw(2'h0);
        far_u.set_raw(2'h1);
        check(wc, 32'h1);
        // edge detection and write-one clear land on the same edge
        apb(1'b1, LPC_FLAG_OFS, 32'h1);
        far_u.set_raw(2'h0);
        fork
            far_u.set_raw(2'h1);
            begin
                @(posedge pclk);
                apb(1'b1, LPC_FLAG_OFS, 32'h1);
            end
        join
        apb(1'b0, LPC_FLAG_OFS, 32'h0);
        check(rd, 32'h1);
        check(wc, 32'h2);
        test_done();
    end
endmodule : lpc_irq_bench

// *** hw/lpc_irq.sv ***
// interrupt and output logic for two low-power comparators behind apb
// assumes raw comparator outputs are asynchronous to pclk
`timescale 1ns/1ps
module lpc_irq
    import lpc_pkg::*;
(
    input  wire logic                  pclk,         // system main clock, 20 MHz
    input  wire logic                  presetn,      // async reset, active low
    input  wire lpc_pkg::lpc_apb_req_s apb_req,      // apb request
    output lpc_pkg::lpc_apb_rsp_s      apb_rsp,      // apb answer
    input  wire logic [1:0]            cmp_raw,      // raw comparator outputs
    input  wire logic                  deep_sleep,   // device is in deep sleep
    output logic [1:0]                 cmp_pin_out,  // unsynchronised pin outputs
    output logic [1:0]                 cmp_on,       // comparator enables to analog
    output logic                       cmp_irq,      // shared cpu interrupt
    output logic                       cmp_wakeup    // wakeup controller request
);
    import lpc_pkg::*;

    lpc_state_s s_q;
    lpc_state_s s_d;

    logic [1:0]  edge_hit;
    logic [1:0]  set_ev;
    logic [1:0]  clr_ev;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] cfg_word;

    // edge detector decode for one comparator
    function automatic logic edge_fires(input logic [1:0] sel, input logic cur,
                                        input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (lpc_edge_e'(sel))
            LPC_EDGE_OFF:  edge_fires = 1'b0;
            LPC_EDGE_RISE: edge_fires = rise;
            LPC_EDGE_FALL: edge_fires = fall;
            LPC_EDGE_BOTH: edge_fires = rise | fall;
            default:       edge_fires = 1'b0;
        endcase
    endfunction : edge_fires

    // configuration word as software sees it
    always_comb begin
        cfg_word = 32'h0000_0000;
        for (int i = 0; i < LPC_NCMP; i++) begin
            cfg_word[i*LPC_CMP_STRIDE+LPC_OUT_BIT] = s_q.sync2[i];
            cfg_word[i*LPC_CMP_STRIDE+LPC_ON_BIT] = s_q.on[i];
            cfg_word[i*LPC_CMP_STRIDE+LPC_SEL_LSB +: 2] = s_q.sel[i*2 +: 2];
        end
    end

    // bus phase decode; zero wait states
    assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_acc = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    // next state
    always_comb begin
        s_d = s_q;
        // two-flop synchroniser, second flop feeds logic
        s_d.sync1 = cmp_raw;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        for (int i = 0; i < LPC_NCMP; i++) begin
            edge_hit[i] = s_q.on[i] & edge_fires(s_q.sel[i*2 +: 2], s_q.sync2[i],
                                                 s_q.prev[i]);
        end
        set_ev = edge_hit;
        if (wr_acc && apb_req.paddr == LPC_FORCE_OFS) begin
            set_ev = edge_hit | apb_req.pwdata[1:0];
        end
        clr_ev = 2'h0;
        if (wr_acc && apb_req.paddr == LPC_FLAG_OFS) begin
            clr_ev = apb_req.pwdata[1:0];
        end
        // set beats clear, all on pclk
        s_d.flag = (s_q.flag & ~clr_ev) | set_ev;
        // wakeup pulse in deep sleep when armed
        s_d.wake = edge_hit & s_q.mask & {2{deep_sleep}};
        // register writes
        if (wr_acc && apb_req.paddr == LPC_CFG_OFS) begin
            for (int i = 0; i < LPC_NCMP; i++) begin
                s_d.on[i] = apb_req.pwdata[i*LPC_CMP_STRIDE+LPC_ON_BIT];
                s_d.sel[i*2 +: 2] = apb_req.pwdata[i*LPC_CMP_STRIDE+LPC_SEL_LSB +: 2];
            end
        end
        if (wr_acc && apb_req.paddr == LPC_MASK_OFS) begin
            s_d.mask = apb_req.pwdata[1:0];
        end
        // read data captured in setup, stands through access
        if (rd_acc) begin
            case (apb_req.paddr)
                LPC_CFG_OFS:    s_d.rdata = cfg_word;
                LPC_FLAG_OFS:   s_d.rdata = {30'h0, s_q.flag};
                LPC_FORCE_OFS:  s_d.rdata = {30'h0, s_q.flag};
                LPC_MASK_OFS:   s_d.rdata = {30'h0, s_q.mask};
                LPC_MASKED_OFS: s_d.rdata = {30'h0, s_q.flag & s_q.mask};
                default:        s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.sel   <= {LPC_SEL_RST, LPC_SEL_RST};
            s_q.on    <= {LPC_ON_RST, LPC_ON_RST};
            s_q.mask  <= LPC_MASK_RST;
            s_q.flag  <= LPC_FLAG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answer; unmapped addresses read zero and raise pslverr
    always_comb begin
        apb_rsp.prdata  = s_q.rdata;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable &
                          (apb_req.paddr > LPC_MASKED_OFS || apb_req.paddr[1:0] != 2'h0);
    end

    // pin path is the raw analog output
    assign cmp_pin_out = cmp_raw;
    assign cmp_on      = s_q.on;
    assign cmp_irq     = |(s_q.flag & s_q.mask);
    assign cmp_wakeup  = |s_q.wake;

    // checks
    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        edge_hit[0] |=> s_q.flag[0]) else $error("edge did not set flag 0");
    a_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_ev[1] && !set_ev[1]) |=> !s_q.flag[1]) else $error("flag 1 not cleared");
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_ev[0] && set_ev[0]) |=> s_q.flag[0]) else $error("clear beat set");
    a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_irq == ((s_q.flag[0] & s_q.mask[0]) | (s_q.flag[1] & s_q.mask[1])))
        else $error("irq line not masked or");
    a_force_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && apb_req.paddr == LPC_FORCE_OFS && apb_req.pwdata[1])
        |=> s_q.flag[1]) else $error("force did not set flag 1");
    a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        ##2 s_q.sync2 == $past(cmp_raw, 2)) else $error("synchroniser depth wrong");
    a_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[0] && s_q.sel[1:0] == 2'h1 && !s_q.sync2[0] && s_q.prev[0])
        |-> !edge_hit[0]) else $error("falling edge fired in rise mode");
    a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.on[1] || s_q.sel[3:2] == 2'h0) |-> !edge_hit[1])
        else $error("disabled comparator fired");
    a_wake_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_wakeup |-> $past(deep_sleep)) else $error("wakeup outside deep sleep");
    a_hold_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.flag[0] && clr_ev[0] == 1'b0) |=> s_q.flag[0])
        else $error("flag 0 dropped without clear");

    // flag set, hold and clear per comparator

    a_flag1_sets: assert property (@(posedge pclk) disable iff (!presetn)
        edge_hit[1]
        |=> s_q.flag[1])
        else $error("edge did not set flag 1");

    a_clear_flag0: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_ev[0] && !set_ev[0])
        |=> !s_q.flag[0])
        else $error("flag 0 not cleared");

    a_set_wins1: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_ev[1] && set_ev[1])
        |=> s_q.flag[1])
        else $error("clear beat set on flag 1");

    a_hold_flag1: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.flag[1] && !clr_ev[1])
        |=> s_q.flag[1])
        else $error("flag 1 dropped without clear");

    a_force_flag0: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && apb_req.paddr == LPC_FORCE_OFS && apb_req.pwdata[0])
        |=> s_q.flag[0])
        else $error("force did not set flag 0");

    a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && apb_req.paddr == LPC_FLAG_OFS && !apb_req.pwdata[0] && s_q.flag[0])
        |=> s_q.flag[0])
        else $error("zero write cleared flag 0");

    a_flag0_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.flag[0] && !set_ev[0])
        |=> !s_q.flag[0])
        else $error("flag 0 set without cause");

    a_flag1_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.flag[1] && !set_ev[1])
        |=> !s_q.flag[1])
        else $error("flag 1 set without cause");

    // flag changes only from their causes

    a_rose0_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.flag[0])
        |-> $past(set_ev[0]))
        else $error("flag 0 rose without set");

    a_rose1_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.flag[1])
        |-> $past(set_ev[1]))
        else $error("flag 1 rose without set");

    a_fell0_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_q.flag[0])
        |-> $past(clr_ev[0]))
        else $error("flag 0 fell without clear");

    a_fell1_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_q.flag[1])
        |-> $past(clr_ev[1]))
        else $error("flag 1 fell without clear");

    a_clr_source: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_ev != 2'h0)
        |-> (wr_acc && apb_req.paddr == LPC_FLAG_OFS))
        else $error("clear without flag write");

    a_force_source: assert property (@(posedge pclk) disable iff (!presetn)
        ((set_ev & ~edge_hit) != 2'h0)
        |-> (wr_acc && apb_req.paddr == LPC_FORCE_OFS))
        else $error("set without edge or force write");

    // edge decode, comparator 0

    a_rise_fires: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[0] && s_q.sel[1:0] == 2'h1 && s_q.sync2[0] && !s_q.prev[0])
        |-> edge_hit[0])
        else $error("rising edge missed on 0");

    a_fall_fires: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[0] && s_q.sel[1:0] == 2'h2 && !s_q.sync2[0] && s_q.prev[0])
        |-> edge_hit[0])
        else $error("falling edge missed on 0");

    a_both_fires: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[0] && s_q.sel[1:0] == 2'h3 && s_q.sync2[0] != s_q.prev[0])
        |-> edge_hit[0])
        else $error("edge missed on 0 in both mode");

    a_fall_only: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[0] && s_q.sel[1:0] == 2'h2 && s_q.sync2[0] && !s_q.prev[0])
        |-> !edge_hit[0])
        else $error("rising edge fired in fall mode");

    a_off0_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.on[0] || s_q.sel[1:0] == 2'h0)
        |-> !edge_hit[0])
        else $error("disabled comparator 0 fired");

    // edge decode, comparator 1, then steady output on both

    a_rise1_fires: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[1] && s_q.sel[3:2] == 2'h1 && s_q.sync2[1] && !s_q.prev[1])
        |-> edge_hit[1])
        else $error("rising edge missed on 1");

    a_fall1_fires: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[1] && s_q.sel[3:2] == 2'h2 && !s_q.sync2[1] && s_q.prev[1])
        |-> edge_hit[1])
        else $error("falling edge missed on 1");

    a_both1_fires: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[1] && s_q.sel[3:2] == 2'h3 && s_q.sync2[1] != s_q.prev[1])
        |-> edge_hit[1])
        else $error("edge missed on 1 in both mode");

    a_fall1_only: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.on[1] && s_q.sel[3:2] == 2'h2 && s_q.sync2[1] && !s_q.prev[1])
        |-> !edge_hit[1])
        else $error("rising edge fired in fall mode on 1");

    a_steady_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.sync2 == s_q.prev)
        |-> (edge_hit == 2'h0))
        else $error("edge fired on steady output");

    // synchroniser stages

    a_sync1_stage: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.sync1 ==
        $past(cmp_raw))
        else $error("first sync stage wrong");

    a_sync2_stage: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.sync2 ==
        $past(s_q.sync1))
        else $error("second sync stage wrong");

    a_prev_stage: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.prev ==
        $past(s_q.sync2))
        else $error("edge history stage wrong");

    // register writes and reads

    a_on_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && apb_req.paddr == LPC_CFG_OFS) |=> s_q.on ==
        {$past(apb_req.pwdata[LPC_CMP_STRIDE+LPC_ON_BIT]), $past(apb_req.pwdata[LPC_ON_BIT])})
        else $error("enable bits not written");

    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && apb_req.paddr == LPC_CFG_OFS) |=> s_q.sel == {$past(apb_req.pwdata[
        LPC_CMP_STRIDE+LPC_SEL_LSB +: 2]), $past(apb_req.pwdata[LPC_SEL_LSB +: 2])})
        else $error("edge selects not written");

    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && apb_req.paddr == LPC_MASK_OFS)
        |=> s_q.mask == $past(apb_req.pwdata[1:0]))
        else $error("mask not written");

    a_masked_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && apb_req.paddr == LPC_MASKED_OFS)
        |=> apb_rsp.prdata == {30'h0, $past(s_q.flag & s_q.mask)})
        else $error("masked view read wrong");

    a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && apb_req.paddr == LPC_FLAG_OFS)
        |=> apb_rsp.prdata == {30'h0, $past(s_q.flag)})
        else $error("flag read wrong");

    a_out_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && apb_req.paddr == LPC_CFG_OFS)
        |=> apb_rsp.prdata[LPC_OUT_BIT] == $past(s_q.sync2[0]))
        else $error("output status read wrong");

    // shared line and wakeup

    a_irq_or: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.flag[1] && s_q.mask[1])
        |-> cmp_irq)
        else $error("unmasked flag 1 missing on line");

    a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.mask == 2'h0)
        |-> !cmp_irq)
        else $error("line high with all masked");

    a_wake_armed: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_wakeup
        |-> $past((edge_hit & s_q.mask) != 2'h0))
        else $error("wakeup without armed edge");

    a_wake_fires: assert property (@(posedge pclk) disable iff (!presetn)
        (deep_sleep && (edge_hit & s_q.mask) != 2'h0)
        |=> cmp_wakeup)
        else $error("armed edge gave no wakeup");

endmodule : lpc_irq

// *** hw/lpc_pkg.sv ***
// package for the low-power comparator interrupt logic: map, fields, state
// assumes a 32-bit apb slave with word-aligned registers
package lpc_pkg;

    // register byte offsets
    localparam logic [11:0] LPC_CFG_OFS    = 12'h000;
    localparam logic [11:0] LPC_FLAG_OFS   = 12'h004;
    localparam logic [11:0] LPC_FORCE_OFS  = 12'h008;
    localparam logic [11:0] LPC_MASK_OFS   = 12'h00C;
    localparam logic [11:0] LPC_MASKED_OFS = 12'h010;

    // configuration register fields, comparator 0 then comparator 1
    localparam int LPC_CMP_STRIDE  = 8;
    localparam int LPC_SEL_LSB     = 4;
    localparam int LPC_OUT_BIT     = 6;
    localparam int LPC_ON_BIT      = 7;
    localparam int LPC_NCMP        = 2;

    // reset values
    localparam logic [1:0] LPC_SEL_RST  = 2'h0;
    localparam logic       LPC_ON_RST   = 1'b0;
    localparam logic [1:0] LPC_MASK_RST = 2'h0;
    localparam logic [1:0] LPC_FLAG_RST = 2'h0;

    // edge selection codes
    typedef enum logic [1:0] {
        LPC_EDGE_OFF  = 2'h0,
        LPC_EDGE_RISE = 2'h1,
        LPC_EDGE_FALL = 2'h2,
        LPC_EDGE_BOTH = 2'h3
    } lpc_edge_e;

    // apb request
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lpc_apb_req_s;

    // apb answer
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lpc_apb_rsp_s;

    // whole state of the block
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [1:0] on;
        logic [3:0] sel;
        logic [1:0] flag;
        logic [1:0] mask;
        logic [1:0] wake;
        logic [31:0] rdata;
    } lpc_state_s;

endpackage : lpc_pkg
